// >>> logic/bwa_pkg.sv
// bwa_pkg: offsets, field positions and codes of the watchpoint action bank
// assumes: shared by the action bank top and its hit-action unit
package bwa_pkg;
  // register offsets on the plain register port
  localparam logic [23:0] BWA_PAYLOAD_OFS = 24'h104018;
  localparam logic [23:0] BWA_ACTION_OFS = 24'h104020;
  localparam logic [23:0] BWA_TRCTL_OFS = 24'h104028;
  localparam logic [23:0] BWA_STATUS_OFS = 24'h104030;
  // action register field positions
  localparam int BWA_INTEN_BIT = 0;
  localparam int BWA_ECNT_EN_BIT = 1;
  localparam int BWA_ECNT_LSB = 2;
  localparam int BWA_ALTER_LSB = 6;
  localparam int BWA_LATCH_LSB = 8;
  localparam int BWA_TRACE_LSB = 12;
  localparam int BWA_TTYPE_BIT = 14;
  localparam int BWA_TSTAMP_BIT = 15;
  localparam int BWA_TRIG_BIT = 16;
  localparam int BWA_PINC_BIT = 17;
  localparam int BWA_PRST_BIT = 18;
  localparam int BWA_PSEL_LSB = 19;
  localparam int BWA_MASTER_LSB = 23;
  localparam int BWA_HALT_BIT = 31;
  localparam logic [63:0] BWA_ACTION_MASK = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] BWA_PAYLOAD_MASK = 64'h0000_0000_0000_0001;
  // field codes
  localparam logic [1:0] BWA_ALTER_CLR = 2'h2;
  localparam logic [1:0] BWA_ALTER_SET = 2'h3;
  localparam logic [1:0] BWA_TRACE_SINGLE = 2'h2;
  localparam logic [1:0] BWA_TRACE_MULTI = 2'h3;
  localparam logic [2:0] BWA_TRIG_PULSE_MODE = 3'h2;
  // debug-module counters are ids 0..7, controller counters 8..15
  localparam logic [3:0] BWA_DM_CNT_LIMIT = 4'h8;
  localparam logic [3:0] BWA_DM_ECNT_LIMIT = 4'h8;
  // trigger low pulse length
  localparam int BWA_TRIG_PULSE_NS = 20;
  localparam int BWA_CLK_NS = 10;
  localparam int BWA_TRIG_PULSE_CYC =
    (BWA_TRIG_PULSE_NS + BWA_CLK_NS - 1) / BWA_CLK_NS;
endpackage

// >>> logic/bwa_hit_unit.sv
// bwa_hit_unit: turns one channel hit into registered action strobes
// assumes: hits are one-cycle pulses from hit logic on core_clk_i
`timescale 1ns/1ns
`default_nettype none
module bwa_hit_unit
  import bwa_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] action_i,
  input wire logic partial_hit_i,
  input wire logic ecnt_zero_i,
  input wire logic exception_i,
  input wire logic is_analyzer_i,
  output logic ecnt_dec_o,
  output logic [3:0] ecnt_sel_o,
  output logic full_hit_o,
  output logic latch_clr_o,
  output logic latch_set_o,
  output logic [3:0] latch_sel_o,
  output logic trace_o,
  output logic trace_multi_o,
  output logic trace_bg_o,
  output logic trace_tstamp_o,
  output logic trig_o,
  output logic pinc_o,
  output logic [3:0] psel_o,
  output logic prst_o,
  output logic halt_o,
  output logic [7:0] halt_master_o
);
  logic ecnt_en;
  logic full;
  logic act;
  logic [1:0] alter;
  logic [1:0] trc;
  assign ecnt_en = action_i[BWA_ECNT_EN_BIT];
  // full hit needs the counter already at zero when decrement is on
  assign full = partial_hit_i && (!ecnt_en || ecnt_zero_i);
  assign act = full && !exception_i;
  assign alter = action_i[BWA_ALTER_LSB +: 2];
  assign trc = action_i[BWA_TRACE_LSB +: 2];

  // registered action strobes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ecnt_dec_o <= 1'b0;
      full_hit_o <= 1'b0;
      latch_clr_o <= 1'b0;
      latch_set_o <= 1'b0;
      trace_o <= 1'b0;
      trig_o <= 1'b0;
      pinc_o <= 1'b0;
      prst_o <= 1'b0;
      halt_o <= 1'b0;
    end else begin
      ecnt_dec_o <= partial_hit_i && ecnt_en
        && (action_i[BWA_ECNT_LSB +: 4] < BWA_DM_ECNT_LIMIT);
      full_hit_o <= full;
      latch_clr_o <= act && (alter == BWA_ALTER_CLR);
      latch_set_o <= act && (alter == BWA_ALTER_SET);
      trace_o <= act && trc[1];
      trig_o <= act && action_i[BWA_TRIG_BIT];
      pinc_o <= act && action_i[BWA_PINC_BIT]
        && (action_i[BWA_PSEL_LSB +: 4] < BWA_DM_CNT_LIMIT);
      prst_o <= act && action_i[BWA_PRST_BIT];
      halt_o <= full && action_i[BWA_HALT_BIT]
        && is_analyzer_i;
    end
  end

  // selectors and trace attributes captured with each strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ecnt_sel_o <= 4'h0;
      latch_sel_o <= 4'h0;
      trace_multi_o <= 1'b0;
      trace_bg_o <= 1'b0;
      trace_tstamp_o <= 1'b0;
      psel_o <= 4'h0;
      halt_master_o <= 8'h00;
    end else if (partial_hit_i) begin
      ecnt_sel_o <= action_i[BWA_ECNT_LSB +: 4];
      latch_sel_o <= action_i[BWA_LATCH_LSB +: 4];
      trace_multi_o <= (trc == BWA_TRACE_MULTI);
      trace_bg_o <= action_i[BWA_TTYPE_BIT];
      trace_tstamp_o <= action_i[BWA_TSTAMP_BIT];
      psel_o <= action_i[BWA_PSEL_LSB +: 4];
      halt_master_o <= action_i[BWA_MASTER_LSB +: 8];
    end
  end

  plain_partial_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    partial_hit_i && ecnt_en
    |=> ecnt_dec_o == (ecnt_sel_o < BWA_DM_ECNT_LIMIT))
    else $error("decrement missing");
  no_act_nonzero_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    partial_hit_i && ecnt_en && !ecnt_zero_i
    |=> !full_hit_o && !trig_o && !pinc_o && !halt_o)
    else $error("action on count");
  latch_clear_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    full && !exception_i && alter == BWA_ALTER_CLR
    |=> latch_clr_o && !latch_set_o)
    else $error("latch clear");
  halt_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    halt_o |-> $past(action_i[BWA_HALT_BIT]) && $past(is_analyzer_i))
    else $error("halt without enable");
  pinc_range_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pinc_o |-> psel_o < BWA_DM_CNT_LIMIT)
    else $error("controller counter incremented");
endmodule
`default_nettype wire

// >>> logic/bwa_action_bank.sv
// bwa_action_bank: action and payload registers of a bus-analyzer channel
// Behaviour
// - decrement on partial hit; act only at zero
// - bits 5:2 pick debug-module event counter
// - alter 10 clears, 11 sets chain latch
// - bits 11:8 pick the chain latch
// - trace 00/01 off, 10 single, 11 multi
// - kind bit: 0 trigger, 1 background message
// - timestamp bit adds timestamp to trace
// - trigger enable 0 leaves pin alone
// - enable and mode 010 pulse pin low
// - bit 17 enables performance counter increment
// - bit 18 resets all debug-module counters
// - bits 22:19 pick counter; controller ids ignored
// - bits 30:23 name master to freeze
// - bit 31 freezes named master on hit
// - freeze only for bus-analyzer channels
// - operand/value hits pass payload to debug module
// - select 0: full 64-bit stored data
// - select 1: address plus low data word
// assumes: register port on core_clk_i, hit inputs on same clock,
// trigger output mode is written here as a small control register
`timescale 1ns/1ns
`default_nettype none
module bwa_action_bank
  import bwa_pkg::*;
#(
  parameter int PULSE_CYC = BWA_TRIG_PULSE_CYC
)(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [23:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [63:0] reg_rdata_o,
  input wire logic partial_hit_i,
  input wire logic ecnt_zero_i,
  input wire logic exception_i,
  input wire logic is_analyzer_i,
  input wire logic oa_iv_hit_i,
  input wire logic [31:0] oper_addr_i,
  input wire logic [63:0] store_data_i,
  output logic ecnt_dec_o,
  output logic [3:0] ecnt_sel_o,
  output logic latch_clr_o,
  output logic latch_set_o,
  output logic [3:0] latch_sel_o,
  output logic trace_o,
  output logic trace_multi_o,
  output logic trace_bg_o,
  output logic trace_tstamp_o,
  output logic pinc_o,
  output logic [3:0] psel_o,
  output logic prst_o,
  output logic halt_o,
  output logic [7:0] halt_master_o,
  output logic trigger_output_pin_n_o,
  output logic payload_valid_o,
  output logic [63:0] payload_o
);
  logic [31:0] action;
  logic trace_payload_select;
  logic [2:0] trigger_output_mode;
  logic trig_hit;
  logic full_hit;
  logic [7:0] pulse_cnt;
  logic trig_fire;
  logic [7:0] low_len;

  // action register, reserved bits never stored
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      action <= 32'h0000_0000;
    end else if (reg_wr_i && reg_addr_i == BWA_ACTION_OFS) begin
      action <= reg_wdata_i[31:0] & BWA_ACTION_MASK[31:0];
    end
  end

  // payload select and trigger mode controls
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trace_payload_select <= 1'b0;
      trigger_output_mode <= 3'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == BWA_PAYLOAD_OFS) begin
        trace_payload_select <= reg_wdata_i[0];
      end
      if (reg_addr_i == BWA_TRCTL_OFS) begin
        trigger_output_mode <= reg_wdata_i[2:0];
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 64'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        BWA_ACTION_OFS: reg_rdata_o <= {32'h0, action};
        BWA_PAYLOAD_OFS: reg_rdata_o <= {63'h0, trace_payload_select};
        BWA_TRCTL_OFS: reg_rdata_o <= {61'h0, trigger_output_mode};
        BWA_STATUS_OFS: reg_rdata_o <= {63'h0, ~trigger_output_pin_n_o};
        default: reg_rdata_o <= 64'h0;
      endcase
    end else begin
      reg_rdata_o <= 64'h0;
    end
  end

  bwa_hit_unit bwa_hit_unit_inst (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .action_i(action),
    .partial_hit_i(partial_hit_i),
    .ecnt_zero_i(ecnt_zero_i),
    .exception_i(exception_i),
    .is_analyzer_i(is_analyzer_i),
    .ecnt_dec_o(ecnt_dec_o),
    .ecnt_sel_o(ecnt_sel_o),
    .full_hit_o(full_hit),
    .latch_clr_o(latch_clr_o),
    .latch_set_o(latch_set_o),
    .latch_sel_o(latch_sel_o),
    .trace_o(trace_o),
    .trace_multi_o(trace_multi_o),
    .trace_bg_o(trace_bg_o),
    .trace_tstamp_o(trace_tstamp_o),
    .trig_o(trig_hit),
    .pinc_o(pinc_o),
    .psel_o(psel_o),
    .prst_o(prst_o),
    .halt_o(halt_o),
    .halt_master_o(halt_master_o)
  );

  // pulse only in the pulse mode; other modes leave pin high
  assign trig_fire = trig_hit
    && (trigger_output_mode == BWA_TRIG_PULSE_MODE);

  // low-going pulse generator, retriggered by each qualifying hit
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_cnt <= 8'h00;
      trigger_output_pin_n_o <= 1'b1;
    end else if (trig_fire) begin
      pulse_cnt <= 8'(PULSE_CYC - 1);
      trigger_output_pin_n_o <= 1'b0;
    end else if (pulse_cnt != 8'h00) begin
      pulse_cnt <= pulse_cnt - 8'h01;
    end else begin
      trigger_output_pin_n_o <= 1'b1;
    end
  end

  // payload towards the debug module on every operand/value hit
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      payload_valid_o <= 1'b0;
      payload_o <= 64'h0;
    end else begin
      payload_valid_o <= oa_iv_hit_i;
      if (oa_iv_hit_i) begin
        if (trace_payload_select) begin
          payload_o <= {oper_addr_i, store_data_i[31:0]};
        end else begin
          payload_o <= store_data_i;
        end
      end
    end
  end

  // length of the current low pulse, watched by the pulse checks
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_len <= 8'h00;
    end else if (trig_fire || trigger_output_pin_n_o) begin
      low_len <= 8'h00;
    end else begin
      low_len <= low_len + 8'h01;
    end
  end

  // register port: reserved bits, readback and idle data
  reserved_zero_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(reg_rd_i) |-> reg_rdata_o[63:32] == 32'h0)
    else $error("reserved bits nonzero");
  action_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == BWA_ACTION_OFS
    |=> reg_rdata_o == {32'h0, $past(action)})
    else $error("action readback wrong");
  payload_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == BWA_PAYLOAD_OFS
    |=> reg_rdata_o == {63'h0, $past(trace_payload_select)})
    else $error("select readback wrong");
  mode_read_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == BWA_TRCTL_OFS
    |=> reg_rdata_o == {61'h0, $past(trigger_output_mode)})
    else $error("mode readback wrong");
  idle_rdata_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !reg_rd_i |=> reg_rdata_o == 64'h0)
    else $error("read data outside read");
  action_store_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    reg_wr_i && reg_addr_i == BWA_ACTION_OFS
    |=> action == ($past(reg_wdata_i[31:0]) & BWA_ACTION_MASK[31:0]))
    else $error("action not stored");

  // trigger pin: quiet unless pulse mode, pulse of fixed length
  trig_quiet_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    trig_hit && trigger_output_mode != BWA_TRIG_PULSE_MODE
    && pulse_cnt == 8'h00 && trigger_output_pin_n_o
    |=> trigger_output_pin_n_o)
    else $error("pin moved");
  pin_cause_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(trigger_output_pin_n_o) |-> $past(trig_fire))
    else $error("pin fell without hit");
  trig_pulse_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    trig_fire |=> !trigger_output_pin_n_o)
    else $error("no low pulse");
  pulse_len_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !trigger_output_pin_n_o |-> low_len < 8'(PULSE_CYC))
    else $error("pulse too long");
  pulse_end_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !trigger_output_pin_n_o && !trig_fire
    && low_len == 8'(PULSE_CYC - 1) |=> trigger_output_pin_n_o)
    else $error("pulse not ended");

  // payload towards the debug module
  payload_strobe_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    oa_iv_hit_i |=> payload_valid_o)
    else $error("payload missing");
  payload_cause_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    payload_valid_o |-> $past(oa_iv_hit_i))
    else $error("payload without hit");
  payload_full_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    oa_iv_hit_i && !trace_payload_select
    |=> payload_o == $past(store_data_i) && payload_valid_o)
    else $error("payload word wrong");
  payload_addr_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    oa_iv_hit_i && trace_payload_select
    |=> payload_o[63:32] == $past(oper_addr_i))
    else $error("no address");
  payload_low_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    oa_iv_hit_i && trace_payload_select
    |=> payload_o[31:0] == $past(store_data_i[31:0]))
    else $error("low data word wrong");

  // hit actions as seen at the bank's outputs
  prst_cause_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    prst_o |-> $past(action[BWA_PRST_BIT]) && full_hit)
    else $error("reset without cause");
  pinc_cause_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    pinc_o |-> $past(action[BWA_PINC_BIT]))
    else $error("increment without enable");
  halt_master_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    halt_o |-> halt_master_o == $past(action[30:23]))
    else $error("wrong master");
  latch_excl_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(latch_clr_o && latch_set_o))
    else $error("latch set and cleared");
  trace_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    trace_o |-> $past(action[BWA_TRACE_LSB + 1]))
    else $error("trace while disabled");
  trace_kind_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(partial_hit_i) |-> trace_bg_o == $past(action[BWA_TTYPE_BIT]))
    else $error("trace kind wrong");
  trace_stamp_a: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $past(partial_hit_i)
    |-> trace_tstamp_o == $past(action[BWA_TSTAMP_BIT]))
    else $error("timestamp flag wrong");

  // main scenarios worth seeing
  pulse_seen_c: cover property (@(posedge core_clk_i) trig_fire);
  halt_seen_c: cover property (@(posedge core_clk_i) halt_o);
  dec_seen_c: cover property (@(posedge core_clk_i) ecnt_dec_o);
  payload_sel_c: cover property (@(posedge core_clk_i)
    payload_valid_o && trace_payload_select);
  latch_set_c: cover property (@(posedge core_clk_i) latch_set_o);
endmodule
`default_nettype wire

// >>> tb/bwa_ecnt_model.sv
// bwa_ecnt_model: event counter of the debug module, far side of the bank
// assumes: bench loads a count, the bank's decrement strobe counts it down
`timescale 1ns/1ns
`default_nettype none
module bwa_ecnt_model (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [1:0] load_val_i,
  input wire logic dec_i,
  output logic zero_o
);
  logic [1:0] count;
  // load from bench, count down on request, hold at zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 2'h0;
    end else if (load_i) begin
      count <= load_val_i;
    end else if (dec_i && count != 2'h0) begin
      count <= count - 2'h1;
    end
  end
  // level seen by the bank together with each hit
  assign zero_o = (count == 2'h0);
endmodule
`default_nettype wire

// >>> tb/bwa_action_bank_tb.sv
// bwa_action_bank_tb: self-checking bench for the watchpoint action bank
// assumes: bwa_ecnt_model plays the event counter, bench plays hit logic
`timescale 1ns/1ns
`default_nettype none
module bwa_action_bank_tb;
  import bwa_pkg::*;
  localparam int PC = 3;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [23:0] reg_addr_i = 24'h0;
  logic [63:0] reg_wdata_i = 64'h0, store_data_i = 64'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, partial_hit_i = 1'b0;
  logic exception_i = 1'b0, is_analyzer_i = 1'b0, oa_iv_hit_i = 1'b0;
  logic [31:0] oper_addr_i = 32'h0;
  logic ld = 1'b0, ecnt_zero_i;
  logic [1:0] ld_val = 2'h0;
  logic [63:0] reg_rdata_o, payload_o;
  logic ecnt_dec_o, latch_clr_o, latch_set_o, trace_o, trace_multi_o;
  logic trace_bg_o, trace_tstamp_o, pinc_o, prst_o, halt_o;
  logic trigger_output_pin_n_o, payload_valid_o;
  logic [3:0] ecnt_sel_o, latch_sel_o, psel_o;
  logic [7:0] halt_master_o;
  logic [31:0] hv, act;
  logic [2:0] mode;
  logic pl_sel, rd_q = 1'b0, hit_q = 1'b0, hit_qq = 1'b0;
  logic [63:0] rq[$], pq[$], wv[5];
  logic [31:0] hq[$], he;
  logic tq[$];
  logic [23:0] ofs[5] = '{BWA_PAYLOAD_OFS, BWA_ACTION_OFS, BWA_TRCTL_OFS,
    BWA_STATUS_OFS, 24'h104038};
  logic [63:0] mk[5] = '{64'h1, 64'hFFFFFFFF, 64'h7, 64'h0, 64'h0};
  integer seed = 32'h2952;
  int failures = 0, checks = 0, tcnt = 0, lowc = 0;

  bwa_action_bank #(.PULSE_CYC(PC)) bwa_action_bank_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .partial_hit_i(partial_hit_i),
    .ecnt_zero_i(ecnt_zero_i), .exception_i(exception_i),
    .is_analyzer_i(is_analyzer_i), .oa_iv_hit_i(oa_iv_hit_i),
    .oper_addr_i(oper_addr_i), .store_data_i(store_data_i),
    .ecnt_dec_o(ecnt_dec_o), .ecnt_sel_o(ecnt_sel_o),
    .latch_clr_o(latch_clr_o), .latch_set_o(latch_set_o),
    .latch_sel_o(latch_sel_o), .trace_o(trace_o),
    .trace_multi_o(trace_multi_o), .trace_bg_o(trace_bg_o),
    .trace_tstamp_o(trace_tstamp_o), .pinc_o(pinc_o), .psel_o(psel_o),
    .prst_o(prst_o), .halt_o(halt_o), .halt_master_o(halt_master_o),
    .trigger_output_pin_n_o(trigger_output_pin_n_o),
    .payload_valid_o(payload_valid_o), .payload_o(payload_o));

  bwa_ecnt_model bwa_ecnt_model_inst (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .load_i(ld),
    .load_val_i(ld_val), .dec_i(ecnt_dec_o), .zero_o(ecnt_zero_i));

  // clock at 100 MHz
  always #5 core_clk_i = ~core_clk_i;

  // all hit outputs gathered into one word, compared field by field
  assign hv = {1'b0, ecnt_dec_o, latch_clr_o, latch_set_o, trace_o, pinc_o,
    prst_o, halt_o, ecnt_sel_o, latch_sel_o, trace_multi_o, trace_bg_o,
    trace_tstamp_o, psel_o, halt_master_o, trigger_output_pin_n_o};

  task automatic chk(input string n, input logic [63:0] s,
                     input logic [63:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // expected strobes and levels one cycle after a partial hit
  function automatic logic [31:0] exph(logic [31:0] a, logic z, logic e,
                                       logic an, logic [2:0] m);
    logic full;
    logic ok;
    full = !a[1] || z;
    ok = full && !e;
    return {1'b0, a[1] && a[5:2] < BWA_DM_ECNT_LIMIT,
      ok && a[7:6] == BWA_ALTER_CLR, ok && a[7:6] == BWA_ALTER_SET,
      ok && a[13], ok && a[17] && a[22:19] < BWA_DM_CNT_LIMIT, ok && a[18],
      full && a[31] && an, a[5:2], a[11:8], a[13:12] == BWA_TRACE_MULTI,
      a[14], a[15], a[22:19], a[30:23],
      !(ok && a[16] && m == BWA_TRIG_PULSE_MODE)};
  endfunction

  // one register cycle; a read notes its expected data
  task automatic bus(input logic w, input logic [23:0] a,
                     input logic [63:0] d, input logic [63:0] e);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (!w) rq.push_back(e);
    @(posedge core_clk_i);
  endtask

  task automatic idle;
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    ld <= 1'b0;
    @(posedge core_clk_i);
  endtask

  // one partial hit with an operand hit beside it, then a quiet gap
  task automatic hit(input logic e, input logic an);
    logic [31:0] ad;
    logic [63:0] d;
    logic [31:0] ex;
    ad = $random(seed);
    d = {$random(seed), $random(seed)};
    ex = exph(act, tcnt == 0, e, an, mode);
    hq.push_back(ex);
    // the pin follows the strobes by one cycle
    tq.push_back(ex[0]);
    pq.push_back(pl_sel ? {ad, d[31:0]} : d);
    if (act[1] && act[5:2] < BWA_DM_ECNT_LIMIT && tcnt != 0) tcnt--;
    partial_hit_i <= 1'b1;
    oa_iv_hit_i <= 1'b1;
    exception_i <= e;
    is_analyzer_i <= an;
    oper_addr_i <= ad;
    store_data_i <= d;
    @(posedge core_clk_i);
    partial_hit_i <= 1'b0;
    oa_iv_hit_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
  endtask

  // note which cycles carry a result
  always @(posedge core_clk_i) begin
    rd_q <= reg_rd_i;
    hit_q <= partial_hit_i;
    hit_qq <= hit_q;
  end

  // compare results against the oldest notes
  always @(negedge core_clk_i) begin
    if (rd_q) chk("rdata", reg_rdata_o, rq.pop_front());
    if (hit_q) begin
      he = hq.pop_front();
      chk("ecnt_dec", 64'(hv[30]), 64'(he[30]));
      chk("latch", 64'(hv[29:28]), 64'(he[29:28]));
      chk("trace", 64'(hv[27]), 64'(he[27]));
      chk("perf", 64'(hv[26:25]), 64'(he[26:25]));
      chk("halt", 64'(hv[24]), 64'(he[24]));
      chk("sel", 64'(hv[23:16]), 64'(he[23:16]));
      chk("attr", 64'(hv[15:13]), 64'(he[15:13]));
      chk("psel", 64'(hv[12:9]), 64'(he[12:9]));
      chk("master", 64'(hv[8:1]), 64'(he[8:1]));
    end
    if (hit_qq) begin
      chk("pin", 64'(trigger_output_pin_n_o), 64'(tq.pop_front()));
    end
    if (payload_valid_o) chk("payload", payload_o, pq.pop_front());
    if (!trigger_output_pin_n_o) lowc++;
    else if (lowc != 0) begin
      chk("pulse_len", 64'(lowc), 64'(PC));
      lowc = 0;
    end
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    // cleared after reset, unmapped place reads zero
    foreach (ofs[i]) bus(1'b0, ofs[i], 64'h0, 64'h0);
    // random writes then back-to-back readback, reserved bits masked
    repeat (4) begin
      foreach (ofs[i]) begin
        wv[i] = {$random(seed), $random(seed)};
        bus(1'b1, ofs[i], wv[i], 64'h0);
      end
      foreach (ofs[i]) bus(1'b0, ofs[i], 64'h0, wv[i] & mk[i]);
    end
    idle;
    // random programming, two hits each so the counter can reach zero
    repeat (20) begin
      act = $random(seed); // every action field random, halt bit and master field included
      mode = ($random(seed) & 1) ? BWA_TRIG_PULSE_MODE : 3'($random(seed));
      pl_sel = 1'($random(seed));
      tcnt = $random(seed) & 3;
      ld <= 1'b1;
      ld_val <= 2'(tcnt);
      bus(1'b1, BWA_ACTION_OFS, {32'h0, act}, 64'h0);
      bus(1'b1, BWA_TRCTL_OFS, {61'h0, mode}, 64'h0);
      bus(1'b1, BWA_PAYLOAD_OFS, {63'h0, pl_sel}, 64'h0);
      idle;
      repeat (2) hit(($random(seed) & 3) == 0, 1'($random(seed)));
    end
    repeat (8) @(posedge core_clk_i);
    summarize;
  end

  // watchdog well past the expected run length
  initial begin
    #200000;
    failures++;
    summarize;
  end
endmodule
`default_nettype wire
